// [hw/tps_serial_port.v]
// serial pcm tdm port: two input and two output streams, framed and gated
`timescale 1ns/1ns
`include "tps_defines.vh"
module tps_serial_port
(
	// clock and reset
	input wire clk_in,
	input wire rstn_in,
	// link pins
	input wire bit_clock_in,
	input wire frame_sync_in,
	input wire sin_in,
	input wire rin_in,
	output wire sout_out,
	output wire sout_oe_n_out,
	output wire rout_out,
	output wire rout_oe_n_out,
	// output gating
	input wire serial_output_gate_in,
	input wire main_ctrl_output_enable_in,
	// configuration pins
	input wire freq_select_in,
	input wire [10:0] register_address_lines_in,
	// status
	output wire [10:0] reg_select_out,
	output wire core_clk_slow_out,
	output wire standby_out,
	output wire frame_locked_out,
	output wire frame_format_gci_out
);
	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	reg [5:0] sync1_q, sync2_q;
	reg bclk_prev_q;
	reg [10:0] addr_s1_q, addr_s2_q;
	wire [5:0] pins_in;
	wire bclk_s, fs_s, sin_s, rin_s, gate_s, fsel_s, edge_w;

	assign pins_in = {freq_select_in, serial_output_gate_in, rin_in, sin_in, frame_sync_in, bit_clock_in};

	always @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			sync1_q <= 6'h00;
			sync2_q <= 6'h00;
			bclk_prev_q <= 1'b0;
			addr_s1_q <= 11'h000;
			addr_s2_q <= 11'h000;
		end
		else
		begin
			sync1_q <= pins_in;
			sync2_q <= sync1_q;
			bclk_prev_q <= sync2_q[0];
			addr_s1_q <= register_address_lines_in;
			addr_s2_q <= addr_s1_q;
		end
	end

	assign bclk_s = sync2_q[0];
	assign fs_s = sync2_q[1];
	assign sin_s = sync2_q[2];
	assign rin_s = sync2_q[3];
	assign gate_s = sync2_q[4];
	assign fsel_s = sync2_q[5];
	// rising edge of the far-end bit clock
	assign edge_w = bclk_s & ~bclk_prev_q;

	////////////////////////////////////////////////////////////////////////
	// reset standby, defaults and strap capture
	reg [2:0] init_cnt_q;
	reg ready_q, fsel_q;
	reg [10:0] reg_sel_q;

	always @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			init_cnt_q <= 3'h0;
			ready_q <= 1'b0;
			fsel_q <= 1'b0;
			reg_sel_q <= 11'h000;
		end
		else
		begin
			if (!ready_q)
			begin
				init_cnt_q <= init_cnt_q + 3'h1;
				if (init_cnt_q == `TPS_INIT_CYCLES)
				begin
					ready_q <= 1'b1;
					fsel_q <= fsel_s;
				end
			end
			if (ready_q)
				reg_sel_q <= addr_s2_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame format detection and half-bit counter
	reg fs_prev_q, idle_lvl_q, locked_q;
	reg [2:0] run_q;
	reg [8:0] hb_q, hb_d;
	wire pulse_end_w;

	assign pulse_end_w = locked_q & (fs_prev_q != idle_lvl_q) & (fs_s == idle_lvl_q);

	always @*
	begin
		hb_d = hb_q + 9'h001;
		if (pulse_end_w)
			hb_d = 9'h000;
	end

	always @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			fs_prev_q <= 1'b1;
			run_q <= 3'h0;
			idle_lvl_q <= 1'b1;
			locked_q <= 1'b0;
			hb_q <= 9'h000;
		end
		else if (ready_q && edge_w)
		begin
			fs_prev_q <= fs_s;
			// a level that stays for several bit clocks is the idle level
			if (fs_s != fs_prev_q)
				run_q <= 3'h0;
			else if (run_q != `TPS_IDLE_RUN)
				run_q <= run_q + 3'h1;
			if (run_q == `TPS_IDLE_RUN)
			begin
				idle_lvl_q <= fs_prev_q;
				locked_q <= 1'b1;
			end
			hb_q <= hb_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// input shifting, byte capture and channel store
	wire [3:0] slot_w;
	wire [4:0] ch_w;
	wire [2:0] bit_w;
	reg [7:0] sin_sh_q, rin_sh_q, sin_byte_q, rin_byte_q;
	reg [7:0] sin_nxt_q, rin_nxt_q, sin_out_sh_q, rin_out_sh_q;
	reg sout_q, rout_q, rd_pend_q, rd_stream_q;
	reg wr_en_d, rd_en_d;
	reg [5:0] wr_addr_d, rd_addr_d;
	reg [7:0] wr_data_d;
	wire [7:0] rd_data_w;
	wire tick_w;

	assign slot_w = hb_d[3:0];
	assign ch_w = hb_d[8:4];
	assign bit_w = hb_d[3:1];
	assign tick_w = ready_q & edge_w;

	always @*
	begin
		wr_en_d = 1'b0;
		wr_addr_d = 6'h00;
		wr_data_d = 8'h00;
		rd_en_d = 1'b0;
		rd_addr_d = 6'h00;
		if (tick_w)
		begin
			// bytes of the channel just finished, then the next channel read ahead
			if (slot_w == `TPS_SLOT_WR_SIN)
			begin
				wr_en_d = 1'b1;
				wr_addr_d = {`TPS_STREAM_SIN, ch_w - 5'h01};
				wr_data_d = sin_byte_q;
			end
			if (slot_w == `TPS_SLOT_WR_RIN)
			begin
				wr_en_d = 1'b1;
				wr_addr_d = {`TPS_STREAM_RIN, ch_w - 5'h01};
				wr_data_d = rin_byte_q;
			end
			if (slot_w == `TPS_SLOT_RD_SIN)
			begin
				rd_en_d = 1'b1;
				rd_addr_d = {`TPS_STREAM_SIN, ch_w + 5'h01};
			end
			if (slot_w == `TPS_SLOT_RD_RIN)
			begin
				rd_en_d = 1'b1;
				rd_addr_d = {`TPS_STREAM_RIN, ch_w + 5'h01};
			end
		end
	end

	tps_frame_ram u_ram
	(
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.wr_en_in(wr_en_d),
		.wr_addr_in(wr_addr_d),
		.wr_data_in(wr_data_d),
		.rd_en_in(rd_en_d),
		.rd_addr_in(rd_addr_d),
		.rd_data_out(rd_data_w)
	);

	always @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			sin_sh_q <= 8'h00;
			rin_sh_q <= 8'h00;
			sin_byte_q <= 8'h00;
			rin_byte_q <= 8'h00;
			sin_nxt_q <= 8'h00;
			rin_nxt_q <= 8'h00;
			sin_out_sh_q <= 8'h00;
			rin_out_sh_q <= 8'h00;
			sout_q <= 1'b1;
			rout_q <= 1'b1;
			rd_pend_q <= 1'b0;
			rd_stream_q <= 1'b0;
		end
		else
		begin
			rd_pend_q <= rd_en_d;
			rd_stream_q <= rd_addr_d[5];
			if (rd_pend_q && rd_stream_q == `TPS_STREAM_SIN)
				sin_nxt_q <= rd_data_w;
			if (rd_pend_q && rd_stream_q == `TPS_STREAM_RIN)
				rin_nxt_q <= rd_data_w;
			if (tick_w && hb_d[0])
			begin
				// sample inputs in the second half of each bit, msb first
				sin_sh_q <= {sin_sh_q[6:0], sin_s};
				rin_sh_q <= {rin_sh_q[6:0], rin_s};
				if (slot_w == `TPS_SLOT_LAST)
				begin
					sin_byte_q <= {sin_sh_q[6:0], sin_s};
					rin_byte_q <= {rin_sh_q[6:0], rin_s};
				end
			end
			if (tick_w && !hb_d[0])
			begin
				if (slot_w == `TPS_SLOT_FIRST)
				begin
					sin_out_sh_q <= sin_nxt_q;
					rin_out_sh_q <= rin_nxt_q;
					sout_q <= sin_nxt_q[7];
					rout_q <= rin_nxt_q[7];
				end
				else
				begin
					sout_q <= sin_out_sh_q[3'h7 - bit_w];
					rout_q <= rin_out_sh_q[3'h7 - bit_w];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output drive gating
	reg oe_n_q;

	always @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			oe_n_q <= 1'b1;
		else
			oe_n_q <= ~(ready_q & gate_s & main_ctrl_output_enable_in);
	end

	assign sout_out = sout_q;
	assign rout_out = rout_q;
	assign sout_oe_n_out = oe_n_q;
	assign rout_oe_n_out = oe_n_q;
	assign reg_select_out = reg_sel_q;
	assign core_clk_slow_out = fsel_q;
	assign standby_out = ~ready_q;
	assign frame_locked_out = locked_q;
	assign frame_format_gci_out = ~idle_lvl_q;
endmodule

// [common/tps_defines.vh]
// constants for the tdm pcm serial port
`ifndef TPS_DEFINES_VH
`define TPS_DEFINES_VH
`define TPS_CLK_HZ 10000000
`define TPS_BIT_CLK_HZ 4096000
`define TPS_STREAM_BPS 2048000
`define TPS_CHANNELS 32
`define TPS_BITS_PER_FRAME 256
`define TPS_HB_W 9
`define TPS_CH_W 5
`define TPS_ADDR_W 11
`define TPS_RAM_AW 6
`define TPS_RAM_DEPTH 64
`define TPS_STREAM_SIN 1'h0
`define TPS_STREAM_RIN 1'h1
`define TPS_IDLE_RUN 3'h4
`define TPS_INIT_CYCLES 3'h4
`define TPS_SLOT_WR_SIN 4'h1
`define TPS_SLOT_WR_RIN 4'h3
`define TPS_SLOT_RD_SIN 4'h5
`define TPS_SLOT_RD_RIN 4'h9
`define TPS_SLOT_LAST 4'hf
`define TPS_SLOT_FIRST 4'h0
`endif

// [hw/tps_frame_ram.v]
// one-frame channel store with registered read data
`timescale 1ns/1ns
module tps_frame_ram
(
	// clock and reset
	input wire clk_in,
	input wire rstn_in,
	// write port
	input wire wr_en_in,
	input wire [5:0] wr_addr_in,
	input wire [7:0] wr_data_in,
	// read port
	input wire rd_en_in,
	input wire [5:0] rd_addr_in,
	output wire [7:0] rd_data_out
);
	reg [7:0] mem [0:63];
	reg [7:0] rd_data_q;

	always @(posedge clk_in)
	begin
		if (wr_en_in)
			mem[wr_addr_in] <= wr_data_in;
	end

	always @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			rd_data_q <= 8'h00;
		else if (rd_en_in)
			rd_data_q <= mem[rd_addr_in];
	end

	assign rd_data_out = rd_data_q;
endmodule

// [testbench/tps_serial_port_assertions.sv]
// pin checks for the tdm pcm serial port
`timescale 1ns/1ns
module tps_serial_port_assertions
(
	// clock and reset
	input wire clk_in,
	input wire rstn_in,
	// link and gating
	input wire sout_out,
	input wire sout_oe_n_out,
	input wire rout_out,
	input wire rout_oe_n_out,
	input wire serial_output_gate_in,
	input wire main_ctrl_output_enable_in,
	// configuration and status
	input wire [10:0] register_address_lines_in,
	input wire [10:0] reg_select_out,
	input wire core_clk_slow_out,
	input wire standby_out,
	input wire frame_locked_out,
	input wire frame_format_gci_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);
	sequence gate_held;
		(serial_output_gate_in && main_ctrl_output_enable_in && !standby_out) [*4];
	endsequence
	sequence sout_moved;
		!sout_oe_n_out && $changed(sout_out);
	endsequence
	drive_on_a: assert property (gate_held |=> !sout_oe_n_out)
		else $error("outputs not driven");
	ctrl_off_a: assert property (!main_ctrl_output_enable_in |=> sout_oe_n_out && rout_oe_n_out)
		else $error("driving with ctrl bit low");
	pin_off_a: assert property (!serial_output_gate_in [*3] |=> sout_oe_n_out && rout_oe_n_out)
		else $error("driving with gate pin low");
	sout_stands_a: assert property (sout_moved |=> $stable(sout_out) [*8])
		else $error("send bit too short");
	rout_stands_a: assert property (!rout_oe_n_out && $changed(rout_out) |=> $stable(rout_out) [*8])
		else $error("receive bit too short");
	addr_follow_a: assert property (($stable(register_address_lines_in) && !standby_out) [*5]
		|-> reg_select_out == register_address_lines_in) else $error("select lags address");
	freq_kept_a: assert property (!standby_out && !$past(standby_out) |-> $stable(core_clk_slow_out))
		else $error("freq mode changed");
	gci_lock_a: assert property (!frame_locked_out |-> !frame_format_gci_out)
		else $error("format before lock");
endmodule
bind tps_serial_port tps_serial_port_assertions tps_serial_port_assertions_inst
(
	.clk_in, .rstn_in, .sout_out, .sout_oe_n_out, .rout_out, .rout_oe_n_out,
	.serial_output_gate_in, .main_ctrl_output_enable_in, .register_address_lines_in,
	.reg_select_out, .core_clk_slow_out, .standby_out, .frame_locked_out, .frame_format_gci_out
);

// [testbench/tps_far_end.sv]
// far-end framer: bit clock, frame pulse and two input streams
`timescale 1ns/1ns
module tps_far_end
(
	// control
	input wire run_in,
	input wire gci_in,
	// link
	output reg bck_out,
	output reg fs_out,
	output reg sin_out,
	output reg rin_out
);
	integer h = 511;
	integer f = 0;
	reg [7:0] sb;
	initial
	begin
		bck_out = 1'h0;
		fs_out = 1'h1;
		sin_out = 1'h0;
		rin_out = 1'h1;
		wait (run_in);
		#37;
		forever
		begin
			h = (h + 1) % 512;
			if (h == 0)
				f = f + 1;
			// byte carries frame number and channel
			sb = {f[2:0], h[8:4]};
			fs_out = (h == 511) ^ !gci_in;
			sin_out = sb[7 - h[3:1]];
			rin_out = ~sb[7 - h[3:1]];
			#400 bck_out = 1'h1;
			#400 bck_out = 1'h0;
		end
	end
endmodule

// [testbench/tps_serial_port_test.sv]
// self-checking bench for the tdm pcm serial port
`timescale 1ns/1ns
`define CHK(a, e) \
	begin \
		compares = compares + 1; \
		if ((a) !== (e)) \
		begin \
			err_total = err_total + 1; \
			$display("Error %0t got %h exp %h", $time, a, e); \
		end \
	end
module tps_serial_port_test;
	reg clk_in = 1'h0;
	reg rstn_in = 1'h0;
	reg serial_output_gate_in = 1'h0;
	reg main_ctrl_output_enable_in = 1'h0;
	reg freq_select_in = 1'h1;
	reg [10:0] register_address_lines_in = 11'h000;
	reg run = 1'h0;
	reg gci = 1'h0;
	wire bit_clock_in, frame_sync_in, sin_in, rin_in;
	wire sout_out, sout_oe_n_out, rout_out, rout_oe_n_out;
	wire [10:0] reg_select_out;
	wire core_clk_slow_out, standby_out, frame_locked_out, frame_format_gci_out;
	integer err_total = 0;
	integer compares = 0;
	always #50 clk_in = ~clk_in;
	tps_serial_port tps_serial_port_inst
	(
		.clk_in, .rstn_in, .bit_clock_in, .frame_sync_in, .sin_in, .rin_in,
		.sout_out, .sout_oe_n_out, .rout_out, .rout_oe_n_out, .serial_output_gate_in,
		.main_ctrl_output_enable_in, .freq_select_in, .register_address_lines_in,
		.reg_select_out, .core_clk_slow_out, .standby_out, .frame_locked_out, .frame_format_gci_out
	);
	tps_far_end tps_far_end_inst
	(
		.run_in(run), .gci_in(gci), .bck_out(bit_clock_in), .fs_out(frame_sync_in), .sin_out(sin_in), .rin_out(rin_in)
	);
	task wrap_up;
		$display("mismatches %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task tick(input integer n);
		repeat (n) @(posedge clk_in);
		#5;
	endtask
	task do_reset(input reg fs, input reg g);
		rstn_in = 1'h0;
		freq_select_in = fs;
		gci = g;
		tick(10);
		`CHK(standby_out, 1'h1)
		`CHK(reg_select_out, 11'h000)
		rstn_in = 1'h1;
		tick(10);
		`CHK(standby_out, 1'h0)
		`CHK(core_clk_slow_out, fs)
	endtask
	task t_addr;
		register_address_lines_in = 11'h5a3;
		tick(4);
		`CHK(reg_select_out, 11'h5a3)
		register_address_lines_in = 11'h7ff;
		tick(4);
		`CHK(reg_select_out, 11'h7ff)
	endtask
	task t_stream(input reg g);
		reg [7:0] ss, rs, e;
		integer n;
		tick(120);
		`CHK(frame_locked_out, 1'h1)
		`CHK(frame_format_gci_out, g)
		n = tps_far_end_inst.f + 2;
		wait (tps_far_end_inst.f == n);
		tick(10);
		serial_output_gate_in = 1'h1;
		main_ctrl_output_enable_in = 1'h1;
		tick(4);
		`CHK(rout_oe_n_out, 1'h0)
		n = n + 2;
		wait (tps_far_end_inst.f == n);
		repeat (512)
		begin
			@(posedge bit_clock_in);
			#350;
			if (tps_far_end_inst.h % 2)
			begin
				ss = {ss[6:0], sout_out};
				rs = {rs[6:0], rout_out};
			end
			e = {n[2:0] - 3'h1, tps_far_end_inst.h[8:4]};
			if (tps_far_end_inst.h[3:0] == 4'hf)
			begin
				`CHK(ss, e)
				`CHK(rs, ~e)
			end
		end
	endtask
	task t_gate;
		main_ctrl_output_enable_in = 1'h0;
		tick(1);
		`CHK(sout_oe_n_out, 1'h1)
		main_ctrl_output_enable_in = 1'h1;
		tick(1);
		`CHK(sout_oe_n_out, 1'h0)
		serial_output_gate_in = 1'h0;
		tick(2);
		`CHK(rout_oe_n_out, 1'h0)
		tick(1);
		`CHK(rout_oe_n_out, 1'h1)
	endtask
	initial
	begin
		#8000000;
		err_total = err_total + 1;
		wrap_up;
	end
	initial
	begin
		do_reset(1'h1, 1'h0);
		run = 1'h1;
		t_addr;
		t_stream(1'h0);
		t_gate;
		do_reset(1'h0, 1'h1);
		t_stream(1'h1);
		wrap_up;
	end
endmodule
